// [xtrig_core.sv]
// Logic analyzer cross-trigger handshake with probe comparator trigger
// Notes on behaviour
// - Once raised, event_out stays high until the far side returns event_out_ack or the analyzer is re-armed.
// - With event_out_ack never rising, event_out falls only when the analyzer is re-armed.
// - event_in_ack rises one sample clock after event_in is seen high.
// - event_out rises nine sample clocks after event_in or a met trigger condition.
// - An acknowledge falls only after the event it answers has fallen.
// - Each probe has a configurable comparator count from one to sixteen.
// - With capture control on, one comparator is reserved for capture filtering.
// - Comparators summed over probes stay within 1024; probes beyond that are unusable.
// - Each probe is trigger-only, data-only, or both.
// - Without a common count, every probe has its own comparator count and width.
`timescale 1ns/1ns
`default_nettype none
module xtrig_core
	import xtrig_pkg::*;
#(
	parameter int NUM_PROBES = 4,
	parameter int PROBE_W = 32,
	parameter bit SAME_CMP_CNT = 1'b0,
	parameter logic [4:0] COMMON_CMP_CNT = 5'h4,
	parameter logic [NUM_PROBES*5-1:0] CMP_COUNTS = {NUM_PROBES{5'h4}},
	parameter logic [NUM_PROBES*8-1:0] PROBE_WIDTHS = {NUM_PROBES{8'h20}}
)
(
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Probes from user logic on the sample clock
	input wire logic [NUM_PROBES*PROBE_W-1:0] probe_in,
	// Capture stream toward storage
	output logic [NUM_PROBES*PROBE_W-1:0] cap_data,
	output logic cap_valid,
	// Cross-trigger handshake
	input wire logic event_in,
	output logic event_in_ack,
	output logic event_out,
	input wire logic event_out_ack,
	// Interrupt
	output logic irq
);

	localparam int PIDX_W = (NUM_PROBES > 1) ? $clog2(NUM_PROBES) : 1;

	// probes usable while the running comparator sum stays in budget
	function automatic int usable_probes();
		int sum;
		int n;
		int c;
		sum = 0;
		n = 0;
		for (int p = 0; p < NUM_PROBES; p++)
		begin
			c = SAME_CMP_CNT ? int'(COMMON_CMP_CNT) : int'(CMP_COUNTS[p*5 +: 5]);
			if (c < 1)
				c = 1;
			if (c > MAX_CMP)
				c = MAX_CMP;
			if (n == p && sum + c <= MAX_TOTAL_CMP)
			begin
				sum = sum + c;
				n = n + 1;
			end
		end
		return n;
	endfunction : usable_probes

	function automatic int total_cmps();
		int sum;
		int c;
		sum = 0;
		for (int p = 0; p < usable_probes(); p++)
		begin
			c = SAME_CMP_CNT ? int'(COMMON_CMP_CNT) : int'(CMP_COUNTS[p*5 +: 5]);
			sum = sum + ((c < 1) ? 1 : ((c > MAX_CMP) ? MAX_CMP : c));
		end
		return sum;
	endfunction : total_cmps

	function automatic logic is_trig(input logic [1:0] m);
		return m != PM_DATA;
	endfunction : is_trig

	function automatic logic is_data(input logic [1:0] m);
		return m != PM_TRIG;
	endfunction : is_data

	localparam int USABLE = usable_probes();
	localparam logic [15:0] USABLE_W = 16'(USABLE);
	localparam logic [15:0] TOTAL_W = 16'(total_cmps());

	// Configuration and status registers
	logic cap_en_ff;
	logic and_mode_ff;
	logic evin_en_ff;
	logic [IRQ_W-1:0] irq_stat_ff;
	logic [IRQ_W-1:0] irq_mask_ff;
	logic [1:0] probe_mode_ff [NUM_PROBES];
	logic [PIDX_W-1:0] sel_probe_ff;
	logic [3:0] sel_cmp_ff;
	logic [PROBE_W-1:0] cmp_val_ff [NUM_PROBES][MAX_CMP];
	logic [MAX_CMP-1:0] cmp_en_ff [NUM_PROBES];

	// Trigger sequencing
	logic armed_ff;
	logic pend_ff;
	logic [3:0] dly_cnt_ff;
	logic event_out_ff;
	logic event_in_ack_ff;
	logic event_in_d_ff;
	logic [31:0] rdata_ff;
	logic [NUM_PROBES*PROBE_W-1:0] cap_data_ff;
	logic cap_valid_ff;

	logic wr_ctrl;
	logic rearm;
	logic [NUM_PROBES-1:0] trig_hit;
	logic [NUM_PROBES-1:0] cap_hit;
	logic trig_cond;
	logic evin_cond;
	logic start;
	logic fire;
	logic ack_seen;
	logic evin_rise;
	logic [IRQ_W-1:0] irq_set;
	logic [PROBE_W-1:0] sel_val;
	logic [MAX_CMP-1:0] sel_en;
	logic [2*NUM_PROBES-1:0] mode_flat;

	assign wr_ctrl = ce && reg_wr && reg_addr == REG_CTRL;
	// Re-arm comes from a host write of the arm bit
	assign rearm = wr_ctrl && reg_wdata[CTRL_ARM_BIT];

	// Per-probe comparator banks
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PROBES; gp++)
		begin : g_probe
			logic [MAX_CMP*PROBE_W-1:0] vals;
			logic [4:0] cnt;
			for (genvar gc = 0; gc < MAX_CMP; gc++)
			begin : g_cmp
				assign vals[gc*PROBE_W +: PROBE_W] = cmp_val_ff[gp][gc];
			end
			// own count per probe unless common count chosen; width is always per probe
			assign cnt = SAME_CMP_CNT ? COMMON_CMP_CNT : CMP_COUNTS[gp*5 +: 5];
			assign mode_flat[gp*2 +: 2] = probe_mode_ff[gp];
			xtrig_probe_cmp #(
				.W(PROBE_W)
			) u_cmp (
				.probe_val(probe_in[gp*PROBE_W +: PROBE_W]),
				.probe_width(PROBE_WIDTHS[gp*8 +: 8]),
				.cmp_count(cnt),
				// data-only and over-budget probes never compare
				.active(gp < USABLE && is_trig(probe_mode_ff[gp])),
				.cmp_val(vals),
				.cmp_en(cmp_en_ff[gp]),
				.cap_ctrl(cap_en_ff),
				.and_mode(and_mode_ff),
				.trig_hit(trig_hit[gp]),
				.cap_hit(cap_hit[gp])
			);
		end
	endgenerate

	// event_in used directly, already on the sample clock
	assign evin_cond = evin_en_ff && event_in;
	assign trig_cond = and_mode_ff ? (&(trig_hit | ~trig_hit_mask())) && (|trig_hit_mask())
		: (|trig_hit);
	assign start = armed_ff && !pend_ff && (evin_cond || trig_cond);
	assign fire = pend_ff && dly_cnt_ff == EVOUT_FIRE_CNT;
	assign ack_seen = event_out_ff && event_out_ack;
	assign evin_rise = event_in && !event_in_d_ff;
	assign irq_set = {evin_rise, ack_seen, fire};

	// Probes that take part in the AND across the instance
	function automatic logic [NUM_PROBES-1:0] trig_hit_mask();
		logic [NUM_PROBES-1:0] m;
		m = '0;
		for (int p = 0; p < NUM_PROBES; p++)
			m[p] = p < USABLE && is_trig(probe_mode_ff[p]) && (|cmp_en_ff[p]);
		return m;
	endfunction : trig_hit_mask

	// Control bits
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cap_en_ff <= CTRL_RESET[CTRL_CAP_EN_BIT];
			and_mode_ff <= CTRL_RESET[CTRL_AND_BIT];
			evin_en_ff <= CTRL_RESET[CTRL_EVIN_EN_BIT];
		end
		else if (wr_ctrl)
		begin
			cap_en_ff <= reg_wdata[CTRL_CAP_EN_BIT];
			and_mode_ff <= reg_wdata[CTRL_AND_BIT];
			evin_en_ff <= reg_wdata[CTRL_EVIN_EN_BIT];
		end
	end

	// Probe modes, comparator select, values and enables
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sel_probe_ff <= '0;
			sel_cmp_ff <= 4'h0;
			for (int p = 0; p < NUM_PROBES; p++)
			begin
				probe_mode_ff[p] <= PROBE_MODE_RESET;
				cmp_en_ff[p] <= '0;
				for (int c = 0; c < MAX_CMP; c++)
					cmp_val_ff[p][c] <= '0;
			end
		end
		else if (ce && reg_wr)
		begin
			case (reg_addr)
				REG_PROBE_MODE:
				begin
					for (int p = 0; p < NUM_PROBES && p < 16; p++)
						probe_mode_ff[p] <= reg_wdata[p*2 +: 2];
				end
				REG_CMP_SEL:
				begin
					sel_probe_ff <= reg_wdata[SEL_PROBE_LSB +: PIDX_W];
					sel_cmp_ff <= reg_wdata[SEL_CMP_LSB +: 4];
				end
				REG_CMP_VAL:
					cmp_val_ff[sel_probe_ff][sel_cmp_ff] <= reg_wdata[PROBE_W-1:0];
				REG_CMP_EN:
					cmp_en_ff[sel_probe_ff] <= reg_wdata[MAX_CMP-1:0];
				default:
				begin
				end
			endcase
		end
	end

	// Arm state and trigger delay
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			armed_ff <= 1'b0;
			pend_ff <= 1'b0;
			dly_cnt_ff <= 4'h0;
		end
		else if (ce)
		begin
			if (rearm)
			begin
				armed_ff <= 1'b1;
				pend_ff <= 1'b0;
				dly_cnt_ff <= 4'h0;
			end
			// count from the trigger source edge
			else if (start)
			begin
				armed_ff <= 1'b0;
				pend_ff <= 1'b1;
				dly_cnt_ff <= 4'h1;
			end
			else if (fire)
			begin
				pend_ff <= 1'b0;
				dly_cnt_ff <= 4'h0;
			end
			else if (pend_ff)
				dly_cnt_ff <= dly_cnt_ff + 4'h1;
		end
	end

	// Event output: set on delay expiry, held until ack or re-arm
	always_ff @(posedge core_clk)
	begin
		if (rst)
			event_out_ff <= 1'b0;
		else if (ce)
		begin
			// re-arm is the only way down without an ack
			if (rearm)
				event_out_ff <= 1'b0;
			else if (fire)
				event_out_ff <= 1'b1;
			else if (ack_seen)
				event_out_ff <= 1'b0;
		end
	end

	// ack follows event_in a cycle later, falling only after it
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			event_in_ack_ff <= 1'b0;
			event_in_d_ff <= 1'b0;
		end
		else if (ce)
		begin
			event_in_ack_ff <= event_in;
			event_in_d_ff <= event_in;
		end
	end

	// Capture stream; trigger-only probes do not reach storage
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cap_data_ff <= '0;
			cap_valid_ff <= 1'b0;
		end
		else if (ce)
		begin
			for (int p = 0; p < NUM_PROBES; p++)
				cap_data_ff[p*PROBE_W +: PROBE_W] <=
					(p < USABLE && is_data(probe_mode_ff[p])) ? probe_in[p*PROBE_W +: PROBE_W] : '0;
			// filter decides which samples are kept
			cap_valid_ff <= !cap_en_ff || (|cap_hit);
		end
	end

	// Interrupt status: set wins over write-one-to-clear
	always_ff @(posedge core_clk)
	begin
		if (rst)
			irq_stat_ff <= '0;
		else if (ce)
		begin
			if (reg_wr && reg_addr == REG_IRQ_STAT)
				irq_stat_ff <= (irq_stat_ff & ~reg_wdata[IRQ_W-1:0]) | irq_set;
			else
				irq_stat_ff <= irq_stat_ff | irq_set;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			irq_mask_ff <= IRQ_MASK_RESET;
		else if (ce && reg_wr && reg_addr == REG_IRQ_MASK)
			irq_mask_ff <= reg_wdata[IRQ_W-1:0];
	end

	assign sel_val = cmp_val_ff[sel_probe_ff][sel_cmp_ff];
	assign sel_en = cmp_en_ff[sel_probe_ff];

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge core_clk)
	begin
		if (rst)
			rdata_ff <= '0;
		else if (ce)
		begin
			rdata_ff <= '0;
			if (reg_rd)
			begin
				case (reg_addr)
					REG_CTRL:
						rdata_ff <= 32'({evin_en_ff, and_mode_ff, cap_en_ff, 1'b0});
					REG_STATUS:
						rdata_ff <= {24'h0, dly_cnt_ff, event_in_ack_ff, event_out_ff,
							pend_ff, armed_ff};
					REG_IRQ_STAT:
						rdata_ff <= 32'(irq_stat_ff);
					REG_IRQ_MASK:
						rdata_ff <= 32'(irq_mask_ff);
					REG_PROBE_MODE:
						rdata_ff <= 32'(mode_flat);
					REG_CMP_SEL:
						rdata_ff <= 32'({8'(sel_probe_ff), 4'h0, sel_cmp_ff});
					REG_CMP_VAL:
						rdata_ff <= 32'(sel_val);
					REG_CMP_EN:
						rdata_ff <= 32'(sel_en);
					REG_INFO:
						rdata_ff <= {TOTAL_W, USABLE_W};
					default:
						rdata_ff <= '0;
				endcase
			end
		end
	end

	assign reg_rdata = rdata_ff;
	assign event_out = event_out_ff;
	assign event_in_ack = event_in_ack_ff;
	assign cap_data = cap_data_ff;
	assign cap_valid = cap_valid_ff;
	assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule : xtrig_core
`default_nettype wire

// [xtrig_pkg.sv]
// Shared constants for the cross-trigger logic analyzer block
package xtrig_pkg;

	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
	localparam logic [7:0] REG_PROBE_MODE = 8'h10;
	localparam logic [7:0] REG_CMP_SEL = 8'h14;
	localparam logic [7:0] REG_CMP_VAL = 8'h18;
	localparam logic [7:0] REG_CMP_EN = 8'h1c;
	localparam logic [7:0] REG_INFO = 8'h20;

	// Control register fields
	localparam int CTRL_ARM_BIT = 0;
	localparam int CTRL_CAP_EN_BIT = 1;
	localparam int CTRL_AND_BIT = 2;
	localparam int CTRL_EVIN_EN_BIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'h8;

	// Interrupt status fields
	localparam int IRQ_FIRE_BIT = 0;
	localparam int IRQ_ACK_BIT = 1;
	localparam int IRQ_EVIN_BIT = 2;
	localparam int IRQ_W = 3;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	// Comparator select fields
	localparam int SEL_CMP_LSB = 0;
	localparam int SEL_PROBE_LSB = 8;

	// Comparator limits
	localparam int MAX_CMP = 16;
	localparam int MAX_TOTAL_CMP = 1024;

	// Event output latency after trigger source, in sample clock cycles
	localparam int EVOUT_DLY_CYC = 9;
	localparam logic [3:0] EVOUT_FIRE_CNT = 4'(EVOUT_DLY_CYC - 1);

	// Probe usage modes
	typedef enum logic [1:0]
	{
		PM_BOTH = 2'h0,
		PM_TRIG = 2'h1,
		PM_DATA = 2'h2,
		PM_RSVD = 2'h3
	} probe_mode_t;

	localparam logic [1:0] PROBE_MODE_RESET = 2'h0;

endpackage : xtrig_pkg

// [xtrig_probe_cmp.sv]
// Comparator bank for one probe: trigger match and capture filter match
`timescale 1ns/1ns
`default_nettype none
module xtrig_probe_cmp
	import xtrig_pkg::*;
#(
	parameter int W = 32
)
(
	// Probe sample and its configuration
	input wire logic [W-1:0] probe_val,
	input wire logic [7:0] probe_width,
	input wire logic [4:0] cmp_count,
	input wire logic active,
	// Comparator setup
	input wire logic [MAX_CMP*W-1:0] cmp_val,
	input wire logic [MAX_CMP-1:0] cmp_en,
	input wire logic cap_ctrl,
	input wire logic and_mode,
	// Results
	output logic trig_hit,
	output logic cap_hit
);

	logic [W-1:0] mask;
	logic [4:0] eff_cnt;
	logic [4:0] trig_cnt;
	logic any_hit;
	logic all_hit;
	logic any_en;

	always_comb
	begin
		mask = '1;
		if (probe_width < 8'(W))
			mask = ~({W{1'b1}} << probe_width);
	end

	assign eff_cnt = (cmp_count == 5'h0) ? 5'h1 : ((cmp_count > 5'(MAX_CMP)) ? 5'(MAX_CMP) : cmp_count);
	// comparator just after the last trigger comparator goes to capture filtering
	assign trig_cnt = (cap_ctrl && eff_cnt == 5'(MAX_CMP)) ? 5'(MAX_CMP - 1) : eff_cnt;

	always_comb
	begin
		any_hit = 1'b0;
		all_hit = 1'b1;
		any_en = 1'b0;
		cap_hit = 1'b0;
		for (int i = 0; i < MAX_CMP; i++)
		begin
			if (5'(i) < trig_cnt && cmp_en[i])
			begin
				any_en = 1'b1;
				if ((probe_val & mask) == (cmp_val[i*W +: W] & mask))
					any_hit = 1'b1;
				else
					all_hit = 1'b0;
			end
			if (cap_ctrl && 5'(i) == trig_cnt && cmp_en[i] &&
				(probe_val & mask) == (cmp_val[i*W +: W] & mask))
				cap_hit = active;
		end
		trig_hit = active && (and_mode ? (any_en && all_hit) : any_hit);
	end

endmodule : xtrig_probe_cmp
`default_nettype wire

// [xtrig_core_properties.sv]
// Assertions on the cross-trigger core ports, bound to the core
`timescale 1ns/1ns
`default_nettype none
module xtrig_core_properties
	import xtrig_pkg::*;
(
	// Clock and control
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Handshake and interrupt
	input wire logic event_in,
	input wire logic event_in_ack,
	input wire logic event_out,
	input wire logic event_out_ack,
	input wire logic irq
);
	logic rearm;
	assign rearm = ce && reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_ARM_BIT];

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	chk_inack_rise: assert property (ce && $rose(event_in) |=> event_in_ack)
		else $error("event_in_ack did not follow event_in");
	chk_inack_fall: assert property ($fell(event_in_ack) |-> !$past(event_in))
		else $error("event_in_ack fell while event_in high");
	chk_out_hold: assert property (ce && event_out && !event_out_ack && !rearm |=> event_out)
		else $error("event_out dropped without ack");
	chk_out_ack_drop: assert property (ce && event_out && event_out_ack |=> !event_out)
		else $error("event_out stayed high after ack");
	chk_out_fall_cause: assert property ($fell(event_out) |-> $past(event_out_ack) || $past(rearm))
		else $error("event_out fell with no ack and no re-arm");
	chk_arm_quiet: assert property (rearm |=> !event_out [*8])
		else $error("event_out rose too soon after arming");
	chk_rdata_idle: assert property (ce && !(reg_rd && reg_addr <= REG_INFO) |=> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	chk_irq_masked: assert property (ce && reg_wr && reg_addr == REG_IRQ_MASK
		&& reg_wdata[IRQ_W-1:0] == 3'h0 |=> !irq)
		else $error("irq high with all sources masked");

	cover property ($rose(event_out));
	cover property ($fell(event_out) && $past(event_out_ack));
	cover property ($rose(irq));
	cover property (!ce && event_in_ack);
endmodule : xtrig_core_properties

bind xtrig_core xtrig_core_properties chk_i (.core_clk(core_clk), .rst(rst), .ce(ce),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .event_in(event_in), .event_in_ack(event_in_ack),
	.event_out(event_out), .event_out_ack(event_out_ack), .irq(irq));
`default_nettype wire

// [xtrig_far_party.sv]
// Far-side model: raises event_in and acknowledges event_out
`timescale 1ns/1ns
`default_nettype none
module xtrig_far_party
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Commands from the bench; ack delay ff means never acknowledge
	input wire logic fire,
	input wire logic [7:0] ack_dly,
	// Handshake with the core
	output logic event_in,
	input wire logic event_in_ack,
	input wire logic event_out,
	output logic event_out_ack
);
	logic [7:0] wait_ff;

	// event_in on the sample clock, dropped once acknowledged
	always_ff @(posedge core_clk)
	begin
		if (rst)
			event_in <= 1'b0;
		else if (fire)
			event_in <= 1'b1;
		else if (event_in_ack)
			event_in <= 1'b0;
	end

	// ack released only after event_out falls
	always_ff @(posedge core_clk)
	begin
		if (rst || !event_out)
		begin
			event_out_ack <= 1'b0;
			wait_ff <= 8'h00;
		end
		else if (wait_ff == ack_dly && ack_dly != 8'hff)
			event_out_ack <= 1'b1;
		else
			wait_ff <= wait_ff + 8'h01;
	end
endmodule : xtrig_far_party
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the cross-trigger core
`timescale 1ns/1ns
`default_nettype none
module testbench
	import xtrig_pkg::*;
;
	typedef struct {logic [7:0] dly; logic [2:0] mask; logic [2:0] stat; logic irq;} row_t;
	row_t rows [3] = '{'{8'h00, 3'h1, 3'h7, 1'b1}, '{8'h05, 3'h4, 3'h7, 1'b1},
		'{8'hff, 3'h2, 3'h5, 1'b0}};
	logic [7:0] ra [5] = '{8'h24, REG_CTRL, REG_STATUS, REG_IRQ_MASK, REG_INFO};
	logic [31:0] rv [5] = '{32'h0, {28'h0, CTRL_RESET}, 32'h0, 32'h0, 32'h0010_0004};
	logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, fire = 1'b0, ce = 1'b1;
	logic [7:0] reg_addr = 8'h00, ack_dly = 8'h00;
	logic [31:0] reg_wdata = 32'h0, rd_val, reg_rdata;
	wire logic event_in, event_in_ack, event_out, event_out_ack, irq;
	int err_total = 0, n_checks = 0, n;

	always #2 core_clk = ~core_clk;

	xtrig_core DUT (.core_clk(core_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.probe_in('0), .cap_data(), .cap_valid(), .event_in(event_in),
		.event_in_ack(event_in_ack), .event_out(event_out), .event_out_ack(event_out_ack),
		.irq(irq));
	xtrig_far_party far (.core_clk(core_clk), .rst(rst), .fire(fire), .ack_dly(ack_dly),
		.event_in(event_in), .event_in_ack(event_in_ack), .event_out(event_out),
		.event_out_ack(event_out_ack));

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic fire_once(input logic [7:0] d);
		@(posedge core_clk);
		fire <= 1'b1;
		ack_dly <= d;
		@(posedge core_clk);
		fire <= 1'b0;
		#1;
	endtask : fire_once

	// Bounded wait for event_out to reach a level; counts edges
	task automatic out_wait(input logic want, output int cyc);
		cyc = 0;
		do
		begin
			@(posedge core_clk);
			#1;
			cyc++;
		end
		while (event_out !== want && cyc < 300);
		if (cyc >= 300)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: event_out wait timed out", $time);
			report_and_stop();
		end
	endtask : out_wait

	initial
	begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		foreach (rows[i])
		begin
			wr(REG_IRQ_MASK, {29'h0, rows[i].mask});
			wr(REG_CTRL, 32'h9);
			fire_once(rows[i].dly);
			check(event_in_ack, 1'b0, "ack early");
			@(posedge core_clk);
			#1;
			check(event_in_ack, 1'b1, "ack late");
			out_wait(1'b1, n);
			check(n + 1, EVOUT_DLY_CYC, "out latency");
			if (rows[i].dly == 8'hff)
			begin
				repeat (20) @(posedge core_clk);
				#1;
				check(event_out, 1'b1, "out dropped unacked");
				wr(REG_CTRL, 32'h9);
				check(event_out, 1'b0, "out after re-arm");
			end
			else
			begin
				out_wait(1'b0, n);
				check(n, rows[i].dly + 2, "out hold");
			end
			rd(REG_IRQ_STAT, rd_val);
			check(rd_val, {29'h0, rows[i].stat}, "irq status");
			check(irq, rows[i].irq, "irq level");
			wr(REG_IRQ_STAT, 32'h7);
			check(irq, 1'b0, "irq cleared");
			$display("Handshake row %0d done", i);
		end
		@(posedge core_clk);
		rst <= 1'b1;
		@(posedge core_clk);
		rst <= 1'b0;
		wr(8'h24, 32'hffff_ffff);
		foreach (ra[i])
		begin
			rd(ra[i], rd_val);
			check(rd_val, rv[i], "reset value");
		end
		$display("Reset values done");
		fire_once(8'h00);
		@(posedge core_clk);
		#1;
		check(event_in_ack, 1'b1, "ack while disarmed");
		repeat (14) @(posedge core_clk);
		#1;
		check(event_out, 1'b0, "fired while disarmed");
		wr(REG_IRQ_MASK, 32'h0);
		wr(REG_CTRL, 32'h9);
		// No ack, so a missed cancel would leave event_out high
		fire_once(8'hff);
		repeat (4) @(posedge core_clk);
		wr(REG_CTRL, 32'h9);
		repeat (14) @(posedge core_clk);
		#1;
		check(event_out, 1'b0, "pending not cancelled");
		$display("Disarmed and cancel cases done");
		// Enable low freezes the delay count
		fire_once(8'h00);
		@(posedge core_clk);
		ce <= 1'b0;
		repeat (12) @(posedge core_clk);
		ce <= 1'b1;
		#1;
		check(event_out, 1'b0, "fired while frozen");
		out_wait(1'b1, n);
		check(n + 1, EVOUT_DLY_CYC, "latency after freeze");
		out_wait(1'b0, n);
		$display("Clock enable case done");
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
